// >>> design/hft_pkg.sv
/*
 Package for the hub frame timer: bit-time constants for high and full speed,
 EOF point offsets, advancement and the timer status carrier.
 Assumes one hub bit time per tick of the bit-time strobe.
*/
package hft_pkg;
   // ==========================================================
   // Counter width and period limits
   localparam int unsigned CW = 16;
   localparam logic [15:0] HS_NOMINAL = 16'hea60;    // 60000
   localparam logic [15:0] FS_NOMINAL = 16'h2ee0;    // 12000
   localparam logic [15:0] HS_MIN_PERIOD = 16'hea00; // 59904
   localparam logic [15:0] HS_MAX_PERIOD = 16'heac0; // 60096
   localparam logic [15:0] FS_MIN_PERIOD = 16'h2eb6; // 11958
   localparam logic [15:0] FS_MAX_PERIOD = 16'h2f0a; // 12042
   // ==========================================================
   // EOF points before end of frame
   localparam logic [15:0] HS_EOF1_BEFORE = 16'h0230; // 560
   localparam logic [15:0] HS_EOF2_BEFORE = 16'h0040; // 64
   localparam logic [15:0] FS_EOF1_BEFORE = 16'h0020; // 32
   localparam logic [15:0] FS_EOF2_BEFORE = 16'h000a; // 10
   // Advancement for decode and reaction delay
   localparam logic [15:0] HS_ADVANCE = 16'h0028;     // 40, legal 40..192
   localparam logic [15:0] FS_ADVANCE = 16'h0010;     // 16, legal 16..20
   // ==========================================================
   // Timer status carried to the repeater
   typedef struct packed {
      logic locked;
      logic eof;
      logic eof1;
      logic eof2;
   } hft_status_t;
endpackage

// >>> design/hft_frame_timer.sv
/*
 Hub (micro)frame timer that locks to start-of-frame tokens.
 Assumes bit_tick pulses once per hub bit time and sof_seen pulses once
 per decoded start-of-frame token; all inputs synchronous to clk.
*/
`timescale 1ns/10ps

module hft_frame_timer (
   input wire logic clk,
   input wire logic resetn,
   input wire logic high_speed,
   input wire logic resume,
   input wire logic bit_tick,
   input wire logic sof_seen,
   input wire logic port_connect_req,
   output hft_pkg::hft_status_t status,
   output logic port_connect_ok,
   output logic [15:0] period
);

   // ==========================================================
   // Speed dependent constants
   function automatic logic [15:0] pick(
      input logic hs,
      input logic [15:0] h,
      input logic [15:0] f
   );
      pick = hs ? h : f;
   endfunction

   // Down value at which an EOF point fires
   function automatic logic [15:0] eof_point(
      input logic hs,
      input logic [15:0] hs_before,
      input logic [15:0] fs_before
   );
      eof_point = pick(hs, hs_before + hft_pkg::HS_ADVANCE, fs_before + hft_pkg::FS_ADVANCE);
   endfunction

   function automatic logic [15:0] count_up(
      input logic [15:0] value
   );
      count_up = value + 16'h0001;
   endfunction

   function automatic logic [15:0] count_down(
      input logic [15:0] value
   );
      count_down = value - 16'h0001;
   endfunction

   function automatic logic in_window(
      input logic [15:0] value,
      input logic [15:0] low,
      input logic [15:0] high
   );
      in_window = (value >= low) && (value <= high);
   endfunction

   // Marks the tick on which the down timer meets a point
   function automatic logic hits(
      input logic [15:0] down,
      input logic [15:0] point
   );
      hits = (down == point);
   endfunction

   logic [15:0] max_period;
   logic [15:0] min_period;
   logic [15:0] eof1_at;
   logic [15:0] eof2_at;

   always_comb begin
      max_period = pick(high_speed, hft_pkg::HS_MAX_PERIOD, hft_pkg::FS_MAX_PERIOD);
      min_period = pick(high_speed, hft_pkg::HS_MIN_PERIOD, hft_pkg::FS_MIN_PERIOD);
      eof1_at = eof_point(high_speed, hft_pkg::HS_EOF1_BEFORE, hft_pkg::FS_EOF1_BEFORE);
      eof2_at = eof_point(high_speed, hft_pkg::HS_EOF2_BEFORE, hft_pkg::FS_EOF2_BEFORE);
   end

   // ==========================================================
   // Timer state
   typedef enum logic [1:0] {
      HFT_IDLE = 2'b00,
      HFT_MEASURE = 2'b01,
      HFT_LOCKED = 2'b11
   } hft_state_t;

   hft_state_t state;
   hft_state_t next_state;
   logic [15:0] down_cnt;
   logic [15:0] next_down_cnt;
   logic [15:0] up_cnt;
   logic [15:0] next_up_cnt;
   logic [15:0] next_period;
   logic rolled;
   logic next_rolled;
   logic last_speed;
   logic next_last_speed;
   logic eof_p;
   logic next_eof_p;
   logic eof1_p;
   logic next_eof1_p;
   logic eof2_p;
   logic next_eof2_p;
   logic locked;
   logic drop_lock;
   logic in_range;
   logic capture;
   logic miss_reload;
   logic at_end;

   // ==========================================================
   // Token and lock decode
   always_comb begin
      locked = (state == HFT_LOCKED);
      // Resume or speed change drops lock
      drop_lock = resume || (high_speed != last_speed);
      in_range = in_window(up_cnt, min_period, max_period);
      capture = sof_seen && (state != HFT_IDLE) && !rolled && in_range;
      miss_reload = sof_seen && locked && !capture;
      at_end = (down_cnt <= 16'h0001);
   end

   // ==========================================================
   // Speed memory
   always_comb begin
      next_last_speed = high_speed;
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         last_speed <= 1'b1;
      end else begin
         last_speed <= next_last_speed;
      end
   end

   // ==========================================================
   // Up counter: bit times since the last token
   always_comb begin
      next_up_cnt = up_cnt;
      if (bit_tick && !rolled) begin
         next_up_cnt = count_up(up_cnt);
      end
      if (sof_seen) begin
         // Tick of the token cycle starts the new count
         next_up_cnt = 16'(bit_tick);
      end
      if (drop_lock) begin
         next_up_cnt = 16'h0000;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         up_cnt <= 16'h0000;
      end else begin
         up_cnt <= next_up_cnt;
      end
   end

   // ==========================================================
   // Rollover flag: set once the count passes the upper limit
   always_comb begin
      next_rolled = rolled;
      if (bit_tick && !rolled) begin
         if (up_cnt >= max_period) begin
            next_rolled = 1'b1;
         end
      end
      if (sof_seen) begin
         next_rolled = 1'b0;
      end
      if (drop_lock) begin
         next_rolled = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rolled <= 1'b0;
      end else begin
         rolled <= next_rolled;
      end
   end

   // ==========================================================
   // Lock state machine
   always_comb begin
      next_state = state;
      if (sof_seen) begin
         case (state)
            HFT_IDLE: begin
               next_state = HFT_MEASURE;
            end
            HFT_MEASURE: begin
               if (capture) begin
                  next_state = HFT_LOCKED;
               end else begin
                  next_state = HFT_MEASURE;
               end
            end
            HFT_LOCKED: begin
               // Missed tokens keep the lock
               next_state = HFT_LOCKED;
            end
            default: begin
               next_state = HFT_IDLE;
            end
         endcase
      end
      if (drop_lock) begin
         next_state = HFT_IDLE;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state <= HFT_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // ==========================================================
   // Measured period register
   always_comb begin
      next_period = period;
      if (capture) begin
         next_period = up_cnt;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         period <= hft_pkg::HS_NOMINAL;
      end else begin
         period <= next_period;
      end
   end

   // ==========================================================
   // Down timer: a count of one or less marks end of frame
   always_comb begin
      next_down_cnt = down_cnt;
      if (bit_tick && locked) begin
         if (at_end) begin
            next_down_cnt = period;
         end else begin
            next_down_cnt = count_down(down_cnt);
         end
      end
      if (capture) begin
         next_down_cnt = up_cnt;
      end else if (miss_reload) begin
         next_down_cnt = period;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         down_cnt <= 16'h0000;
      end else begin
         down_cnt <= next_down_cnt;
      end
   end

   // ==========================================================
   // End-of-frame strobe
   always_comb begin
      next_eof_p = 1'b0;
      if (bit_tick && locked && !drop_lock) begin
         next_eof_p = at_end;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         eof_p <= 1'b0;
      end else begin
         eof_p <= next_eof_p;
      end
   end

   // ==========================================================
   // EOF1 and EOF2 strobes, only while locked
   always_comb begin
      next_eof1_p = 1'b0;
      next_eof2_p = 1'b0;
      if (bit_tick && locked && !drop_lock) begin
         next_eof1_p = hits(down_cnt, eof1_at);
         next_eof2_p = hits(down_cnt, eof2_at);
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         eof1_p <= 1'b0;
         eof2_p <= 1'b0;
      end else begin
         eof1_p <= next_eof1_p;
         eof2_p <= next_eof2_p;
      end
   end

   // ==========================================================
   // Repeater outputs
   always_comb begin
      status.locked = locked;
      status.eof = eof_p;
      status.eof1 = eof1_p;
      status.eof2 = eof2_p;
      port_connect_ok = port_connect_req && locked;
   end

endmodule

// >>> verification/hft_frame_timer_asserts.sv
/* Port checker for the frame timer.
   Assumes bit_tick is high every cycle and full speed while locked. */
`timescale 1ns/10ps
module hft_frame_timer_asserts (
   input wire logic clk,
   input wire logic resetn,
   input wire logic high_speed,
   input wire logic resume,
   input wire logic bit_tick,
   input wire logic sof_seen,
   input wire logic port_connect_req,
   input wire hft_pkg::hft_status_t status,
   input wire logic port_connect_ok,
   input wire logic [15:0] period
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   // ==========
   // Assertions
   a_conn_gated: assert property (port_connect_ok == (port_connect_req && status.locked))
      else $error("connect not gated by lock");
   a_resume_unlock: assert property (resume |=> !status.locked)
      else $error("lock kept through resume");
   a_speed_unlock: assert property ($changed(high_speed) |=> !status.locked)
      else $error("lock kept through speed change");
   a_eof1_locked: assert property (status.eof1 |-> $past(status.locked))
      else $error("eof1 while unlocked");
   a_eof2_locked: assert property (status.eof2 |-> $past(status.locked))
      else $error("eof2 while unlocked");
   a_lock_on_sof: assert property ($rose(status.locked) |-> $past(sof_seen))
      else $error("lock rose without token");
   a_eof_spacing: assert property (status.eof1 && !high_speed |-> ##22 status.eof2)
      else $error("eof1 to eof2 spacing wrong");
   a_period_hold: assert property (!sof_seen |=> $stable(period))
      else $error("period moved without token");
   a_lock_holds: assert property (status.locked && !resume && !$changed(high_speed) |=> status.locked)
      else $error("lock lost");
   c_lock: cover property ($rose(status.locked));
   c_eof: cover property (status.eof && status.locked);
   c_eof2: cover property (status.eof2);
endmodule
bind hft_frame_timer hft_frame_timer_asserts hft_frame_timer_asserts_i (.clk(clk), .resetn(resetn),
   .high_speed(high_speed), .resume(resume), .bit_tick(bit_tick), .sof_seen(sof_seen),
   .port_connect_req(port_connect_req), .status(status), .port_connect_ok(port_connect_ok), .period(period));

// >>> verification/hft_sof_host.sv
/* Upstream host model: bit ticks and start-of-frame tokens.
   Assumes the bench sets gap and send; tokens skipped while send is low. */
`timescale 1ns/10ps
module hft_sof_host (
   input wire logic clk,
   input wire logic send,
   input wire logic [15:0] gap,
   output logic bit_tick,
   output logic sof_seen
);
   logic [15:0] cnt = 16'h0000;
   initial bit_tick = 1'b1;
   initial sof_seen = 1'b0;
   always @(negedge clk) begin
      cnt <= (cnt + 16'h0001 >= gap) ? 16'h0000 : cnt + 16'h0001;
      sof_seen <= send && (cnt + 16'h0001 >= gap);
   end
endmodule

// >>> verification/tb.sv
/* Self-checking bench for the frame timer at full speed.
   Assumes the host model supplies ticks and tokens. */
`timescale 1ns/10ps
module tb;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic high_speed = 1'b0;
   logic resume = 1'b0;
   logic req = 1'b0;
   logic send = 1'b1;
   logic [15:0] gap = 16'h2ee0;
   logic [15:0] p0;
   logic bit_tick;
   logic sof_seen;
   logic port_connect_ok;
   logic [15:0] period;
   hft_pkg::hft_status_t status;
   int num_errors = 0;
   int check_count = 0;
   always #2.5 clk = ~clk;
   always @(negedge clk) req <= 1'($urandom);
   hft_sof_host hft_sof_host_i (.clk(clk), .send(send), .gap(gap), .bit_tick(bit_tick), .sof_seen(sof_seen));
   hft_frame_timer hft_frame_timer_i (.clk(clk), .resetn(resetn), .high_speed(high_speed), .resume(resume),
      .bit_tick(bit_tick), .sof_seen(sof_seen), .port_connect_req(req), .status(status),
      .port_connect_ok(port_connect_ok), .period(period));
   task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task wait_sof(input int n);
      repeat (n) begin
         @(posedge clk);
         while (sof_seen !== 1'b1) @(posedge clk);
      end
      repeat (2) @(negedge clk);
      #1;
   endtask
   function automatic logic [15:0] near(input logic [15:0] p, input logic [15:0] g);
      return 16'(p + 16'h0001 >= g && p <= g + 16'h0001);
   endfunction
   task lock_state(input logic exp);
      check("locked", 16'(status.locked), 16'(exp));
      check("connect", 16'(port_connect_ok), 16'(req & exp));
   endtask
   task eof_timing();
      int n;
      n = 0;
      while (status.eof1 !== 1'b1) @(negedge clk);
      while (status.eof !== 1'b1) begin
         @(negedge clk);
         n++;
      end
      check("eof1_to_eof", 16'(n), hft_pkg::FS_EOF1_BEFORE + hft_pkg::FS_ADVANCE - 16'h0001);
      n = 0;
      @(negedge clk);
      n++;
      while (status.eof !== 1'b1) begin
         @(negedge clk);
         n++;
      end
      check("eof_period", 16'(n), gap);
   endtask
   task conclude();
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      #500000;
      num_errors++;
      conclude();
   end
   initial begin
      void'($urandom(32'hb94d6217));
      gap = hft_pkg::FS_MIN_PERIOD + 16'($urandom % 85);
      repeat (3) @(negedge clk);
      resetn = 1'b1;
      #1 lock_state(1'b0);
      wait_sof(2);
      lock_state(1'b1);
      check("period", near(period, gap), 16'h0001);
      p0 = period;
      send = 1'b0;
      fork
         repeat (2 * int'(gap)) @(negedge clk);
         eof_timing();
      join
      send = 1'b1;
      wait_sof(1);
      lock_state(1'b1);
      check("period", period, p0);
      @(negedge clk) resume = 1'b1;
      @(negedge clk) resume = 1'b0;
      #1 lock_state(1'b0);
      gap = 16'h2af8;
      wait_sof(2);
      lock_state(1'b0);
      gap = hft_pkg::FS_MAX_PERIOD;
      wait_sof(1);
      lock_state(1'b1);
      check("period", near(period, gap), 16'h0001);
      high_speed = 1'b1;
      repeat (2) @(negedge clk);
      #1 lock_state(1'b0);
      conclude();
   end
endmodule
